// ===== shared/uart_pkg.sv
// constants shared by the serial channel and its transmit fifo
package uart_pkg;
   // ------------------------------------------------------------
   // sizes
   // ------------------------------------------------------------
   localparam int DATA_W = 8;
   localparam int FIFO_DEPTH = 16;
   localparam int ADDR_W = 8;
   localparam int PRE_W = 5;
   localparam int OVS_W = 4;
   localparam int BIT_IDX_W = 3;

   // ------------------------------------------------------------
   // register byte offsets
   // ------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFS_MODE = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_CFG = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_CTL = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_RATE = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_TXD = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_RXD = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_STAT = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_PDIR = 8'h1C;
   localparam logic [ADDR_W-1:0] OFS_PDAT = 8'h20;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int MODE_CLK_EXT = 3;
   localparam int MODE_TWO_STOP = 4;
   localparam int MODE_PAR_ODD = 5;
   localparam int MODE_PAR_EN = 6;
   localparam int MODE_SLEEP = 7;
   localparam int CFG_DIV_LSB = 0;
   localparam int CFG_FLOW_SEL = 2;
   localparam int CFG_FLOW_DIS = 4;
   localparam int CFG_OPEN_DRAIN = 5;
   localparam int CFG_POL_REV = 6;
   localparam int CTL_TX_EN = 0;
   localparam int CTL_RX_EN = 2;
   localparam int CTL_DATA_INV = 6;
   localparam int PIN_RX = 0;
   localparam int PIN_CLK = 1;
   localparam int PIN_FLOW = 2;
   localparam int STAT_TX_FULL = 0;
   localparam int STAT_TX_EMPTY = 1;
   localparam int STAT_RX_FULL = 2;
   localparam int STAT_OVERRUN = 3;
   localparam int STAT_FRAMING = 4;
   localparam int STAT_PARITY = 5;
   localparam int STAT_TX_BUSY = 6;
   localparam int STAT_COLLISION = 7;

   // ------------------------------------------------------------
   // reset values and encodings
   // ------------------------------------------------------------
   localparam logic [DATA_W-1:0] REG_RST = 8'h00;
   localparam logic [DATA_W-1:0] PDAT_RST = 8'hFF;
   localparam logic [1:0] DIV_F1 = 2'h0;
   localparam logic [1:0] DIV_F8 = 2'h1;
   localparam logic [PRE_W-1:0] PRE_F8_MASK = 5'h07;
   localparam logic [PRE_W-1:0] PRE_F32_MASK = 5'h1F;
   localparam logic [OVS_W-1:0] OVS_MID = 4'h7;
   localparam logic [OVS_W-1:0] OVS_LAST = 4'hF;
   localparam logic [BIT_IDX_W-1:0] LAST_DATA_BIT = 3'h7;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_START = 3'b001,
      ST_DATA = 3'b011,
      ST_PARITY = 3'b010,
      ST_STOP = 3'b110
   } frame_state_e;
endpackage

// ===== hw/sync_fifo.sv
// synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module sync_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic fill_valid,
   output logic fill_ready,
   input wire logic [WIDTH-1:0] fill_data,
   output logic drain_valid,
   input wire logic drain_ready,
   output logic [WIDTH-1:0] drain_data
);
   localparam int PTR_W = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PTR_W-1:0] wr_ptr_q;
   logic [PTR_W-1:0] rd_ptr_q;
   logic [PTR_W:0] count_q;
   logic push;
   logic pop;

   assign fill_ready = (count_q != DEPTH[PTR_W:0]);
   assign drain_valid = (count_q != '0);
   assign drain_data = mem_q[rd_ptr_q];
   assign push = fill_valid && fill_ready;
   assign pop = drain_valid && drain_ready;

   always_ff @(posedge pclk) begin
      if (push) begin
         mem_q[wr_ptr_q] <= fill_data;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q <= '0;
      end else begin
         if (push) begin
            wr_ptr_q <= wr_ptr_q + 1'b1;
         end
         if (pop) begin
            rd_ptr_q <= rd_ptr_q + 1'b1;
         end
         if (push && !pop) begin
            count_q <= count_q + 1'b1;
         end else if (pop && !push) begin
            count_q <= count_q - 1'b1;
         end
      end
   end
endmodule

// ===== hw/uart_channel.sv
// asynchronous serial channel with pin assignment, sleep (not on the third channel), inversion and collision check (both third channel only)
`timescale 1ns/1ps
module uart_channel #(
   parameter bit THIRD_CHANNEL = 1'b0
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic serial_out_pin_level,
   output logic serial_out_pin_oe,
   input wire logic serial_in_pin_sense,
   input wire logic xfer_clock_pin_sense,
   output logic xfer_clock_pin_drive,
   output logic xfer_clock_pin_oe,
   input wire logic flow_control_pin_sense,
   output logic flow_control_pin_drive,
   output logic flow_control_pin_oe,
   output logic rx_req,
   output logic tx_req,
   output logic collision_req
);
   localparam int DW = uart_pkg::DATA_W;

   // ------------------------------------------------------------
   // registers and apb slave
   // ------------------------------------------------------------
   logic [DW-1:0] mode_q, cfg_q, ctl_q, rate_q, pdir_q, pdat_q;
   logic [DW-1:0] rx_buf_q;
   logic rx_full_q, overrun_q, framing_q, parity_err_q, collision_q;
   logic pready_q, pslverr_q;
   logic [31:0] prdata_q;
   logic fifo_ready, fifo_valid, fifo_pop;
   logic [DW-1:0] fifo_data;
   logic access, wr_en, rd_en, mapped, stall;
   logic [DW-1:0] rd_word, stat_word, pin_word;
   logic tx_busy;

   assign mapped = (paddr == uart_pkg::OFS_MODE) || (paddr == uart_pkg::OFS_CFG)
      || (paddr == uart_pkg::OFS_CTL) || (paddr == uart_pkg::OFS_RATE)
      || (paddr == uart_pkg::OFS_TXD) || (paddr == uart_pkg::OFS_RXD)
      || (paddr == uart_pkg::OFS_STAT) || (paddr == uart_pkg::OFS_PDIR)
      || (paddr == uart_pkg::OFS_PDAT);
   // a transmit-data write to a full fifo holds the bus in its access phase until a slot frees
   assign stall = pwrite && (paddr == uart_pkg::OFS_TXD) && !fifo_ready;
   assign access = psel && !pready_q && !stall;
   assign wr_en = access && pwrite && mapped;
   assign rd_en = access && !pwrite && mapped;

   assign stat_word = {collision_q, tx_busy, parity_err_q, framing_q, overrun_q,
      rx_full_q, !fifo_valid, !fifo_ready};
   assign pin_word = {5'h00, flow_control_pin_sense, xfer_clock_pin_sense,
      serial_in_pin_sense};

   always_comb begin
      rd_word = '0;
      if (paddr == uart_pkg::OFS_MODE) begin
         rd_word = mode_q;
      end else if (paddr == uart_pkg::OFS_CFG) begin
         rd_word = cfg_q;
      end else if (paddr == uart_pkg::OFS_CTL) begin
         rd_word = ctl_q;
      end else if (paddr == uart_pkg::OFS_RATE) begin
         rd_word = rate_q;
      end else if (paddr == uart_pkg::OFS_RXD) begin
         rd_word = (THIRD_CHANNEL && ctl_q[uart_pkg::CTL_DATA_INV]) ? ~rx_buf_q : rx_buf_q;
      end else if (paddr == uart_pkg::OFS_STAT) begin
         rd_word = stat_word;
      end else if (paddr == uart_pkg::OFS_PDIR) begin
         rd_word = pdir_q;
      end else if (paddr == uart_pkg::OFS_PDAT) begin
         rd_word = pin_word;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= '0;
      end else begin
         pready_q <= access;
         pslverr_q <= access && !mapped;
         if (rd_en) begin
            prdata_q <= {24'h00_0000, rd_word};
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_q <= uart_pkg::REG_RST;
         cfg_q <= uart_pkg::REG_RST;
         ctl_q <= uart_pkg::REG_RST;
         rate_q <= uart_pkg::REG_RST;
         pdir_q <= uart_pkg::REG_RST;
         pdat_q <= uart_pkg::PDAT_RST;
      end else if (wr_en) begin
         if (paddr == uart_pkg::OFS_MODE) begin
            mode_q <= pwdata[DW-1:0];
         end else if (paddr == uart_pkg::OFS_CFG) begin
            cfg_q <= pwdata[DW-1:0];
         end else if (paddr == uart_pkg::OFS_CTL) begin
            ctl_q <= pwdata[DW-1:0];
         end else if (paddr == uart_pkg::OFS_RATE) begin
            rate_q <= pwdata[DW-1:0];
         end else if (paddr == uart_pkg::OFS_PDIR) begin
            pdir_q <= pwdata[DW-1:0];
         end else if (paddr == uart_pkg::OFS_PDAT) begin
            pdat_q <= pwdata[DW-1:0];
         end
      end
   end

   // inversion happens as the word enters the buffer, before framing
   logic [DW-1:0] fill_word;
   assign fill_word = (THIRD_CHANNEL && ctl_q[uart_pkg::CTL_DATA_INV]) ? ~pwdata[DW-1:0]
      : pwdata[DW-1:0];

   sync_fifo #(
      .WIDTH(uart_pkg::DATA_W),
      .DEPTH(uart_pkg::FIFO_DEPTH)
   ) tx_fifo (
      .pclk(pclk),
      .presetn(presetn),
      .fill_valid(wr_en && (paddr == uart_pkg::OFS_TXD)),
      .fill_ready(fifo_ready),
      .fill_data(fill_word),
      .drain_valid(fifo_valid),
      .drain_ready(fifo_pop),
      .drain_data(fifo_data)
   );

   // ------------------------------------------------------------
   // clock source and bit rate generator
   // ------------------------------------------------------------
   logic [uart_pkg::PRE_W-1:0] pre_q;
   logic [DW-1:0] brg_q;
   logic clk_prev_q, src_tick, tick16, use_ext, pre_tick;

   // the third channel has no external clock path at all
   assign use_ext = !THIRD_CHANNEL && mode_q[uart_pkg::MODE_CLK_EXT]
      && !pdir_q[uart_pkg::PIN_CLK];
   assign pre_tick = (cfg_q[uart_pkg::CFG_DIV_LSB +: 2] == uart_pkg::DIV_F1) ? 1'b1
      : (cfg_q[uart_pkg::CFG_DIV_LSB +: 2] == uart_pkg::DIV_F8)
      ? ((pre_q & uart_pkg::PRE_F8_MASK) == '0) : ((pre_q & uart_pkg::PRE_F32_MASK) == '0);
   assign src_tick = use_ext ? (xfer_clock_pin_sense && !clk_prev_q) : pre_tick;
   assign tick16 = src_tick && (brg_q == '0);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_q <= '0;
         clk_prev_q <= 1'b0;
         brg_q <= '0;
      end else begin
         pre_q <= pre_q + 1'b1;
         clk_prev_q <= xfer_clock_pin_sense;
         if (src_tick) begin
            brg_q <= (brg_q == '0) ? rate_q : brg_q - 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // transmitter
   // ------------------------------------------------------------
   uart_pkg::frame_state_e tx_state_q;
   logic [DW-1:0] tx_shift_q;
   logic [uart_pkg::OVS_W-1:0] tx_phase_q;
   logic [uart_pkg::BIT_IDX_W-1:0] tx_idx_q;
   logic tx_par_q, tx_stop2_q, tx_bit, cts_ok, tx_start;
   logic flow_active;

   assign flow_active = !cfg_q[uart_pkg::CFG_FLOW_DIS];
   assign cts_ok = !(flow_active && !cfg_q[uart_pkg::CFG_FLOW_SEL])
      || !flow_control_pin_sense;
   assign tx_start = (tx_state_q == uart_pkg::ST_IDLE) && tick16 && fifo_valid
      && ctl_q[uart_pkg::CTL_TX_EN] && cts_ok;
   assign fifo_pop = tx_start;
   assign tx_busy = (tx_state_q != uart_pkg::ST_IDLE);

   always_comb begin
      case (tx_state_q)
         uart_pkg::ST_START: tx_bit = 1'b0;
         uart_pkg::ST_DATA: tx_bit = tx_shift_q[0];
         uart_pkg::ST_PARITY: tx_bit = tx_par_q;
         default: tx_bit = 1'b1;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_state_q <= uart_pkg::ST_IDLE;
         tx_shift_q <= '0;
         tx_phase_q <= '0;
         tx_idx_q <= '0;
         tx_par_q <= 1'b0;
         tx_stop2_q <= 1'b0;
         tx_req <= 1'b0;
      end else begin
         tx_req <= 1'b0;
         if (tx_start) begin
            tx_state_q <= uart_pkg::ST_START;
            tx_shift_q <= fifo_data;
            tx_par_q <= (^fifo_data) ^ mode_q[uart_pkg::MODE_PAR_ODD];
            tx_phase_q <= '0;
            tx_idx_q <= '0;
            tx_stop2_q <= mode_q[uart_pkg::MODE_TWO_STOP];
         end else if (tick16 && tx_busy) begin
            tx_phase_q <= tx_phase_q + 1'b1;
            if (tx_phase_q == uart_pkg::OVS_LAST) begin
               case (tx_state_q)
                  uart_pkg::ST_START: begin
                     tx_state_q <= uart_pkg::ST_DATA;
                  end
                  uart_pkg::ST_DATA: begin
                     tx_shift_q <= {1'b0, tx_shift_q[DW-1:1]};
                     tx_idx_q <= tx_idx_q + 1'b1;
                     if (tx_idx_q == uart_pkg::LAST_DATA_BIT) begin
                        tx_state_q <= mode_q[uart_pkg::MODE_PAR_EN] ? uart_pkg::ST_PARITY
                           : uart_pkg::ST_STOP;
                     end
                  end
                  uart_pkg::ST_PARITY: begin
                     tx_state_q <= uart_pkg::ST_STOP;
                  end
                  default: begin
                     if (tx_stop2_q) begin
                        tx_stop2_q <= 1'b0;
                     end else begin
                        tx_state_q <= uart_pkg::ST_IDLE;
                        tx_req <= 1'b1;
                     end
                  end
               endcase
            end
         end
      end
   end

   // ------------------------------------------------------------
   // pins
   // ------------------------------------------------------------
   logic pol_rev, line_level;
   assign pol_rev = THIRD_CHANNEL && cfg_q[uart_pkg::CFG_POL_REV];
   assign line_level = tx_bit ^ pol_rev;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         serial_out_pin_level <= 1'b1;
         serial_out_pin_oe <= 1'b1;
         xfer_clock_pin_drive <= 1'b1;
         xfer_clock_pin_oe <= 1'b0;
         flow_control_pin_drive <= 1'b1;
         flow_control_pin_oe <= 1'b0;
      end else begin
         serial_out_pin_level <= line_level;
         // open-drain only pulls low, a high level is left to the pull-up
         serial_out_pin_oe <= !cfg_q[uart_pkg::CFG_OPEN_DRAIN] || !line_level;
         xfer_clock_pin_drive <= pdat_q[uart_pkg::PIN_CLK];
         xfer_clock_pin_oe <= pdir_q[uart_pkg::PIN_CLK] && !use_ext;
         if (flow_active && cfg_q[uart_pkg::CFG_FLOW_SEL]) begin
            flow_control_pin_drive <= !(ctl_q[uart_pkg::CTL_RX_EN] && !rx_full_q);
            flow_control_pin_oe <= 1'b1;
         end else begin
            flow_control_pin_drive <= pdat_q[uart_pkg::PIN_FLOW];
            flow_control_pin_oe <= !flow_active && pdir_q[uart_pkg::PIN_FLOW];
         end
      end
   end

   // ------------------------------------------------------------
   // collision check
   // ------------------------------------------------------------
   logic col_hit;
   // mid-bit of the transmit clock stands for its rising edge
   assign col_hit = THIRD_CHANNEL && tx_busy && tick16 && (tx_phase_q == uart_pkg::OVS_MID)
      && (serial_out_pin_level != serial_in_pin_sense);

   // ------------------------------------------------------------
   // receiver
   // ------------------------------------------------------------
   uart_pkg::frame_state_e rx_state_q;
   logic [DW-1:0] rx_shift_q;
   logic [uart_pkg::OVS_W-1:0] rx_phase_q;
   logic [uart_pkg::BIT_IDX_W-1:0] rx_idx_q;
   logic rx_par_bad_q, rx_stop2_q, rx_bit, rx_sample, rx_done, rx_keep, rx_frame_bad;
   logic rd_rxd, clr_stat;

   // a pin set to output reads as idle line to the receiver
   assign rx_bit = pdir_q[uart_pkg::PIN_RX] ? 1'b1 : (serial_in_pin_sense ^ pol_rev);
   assign rx_sample = tick16 && (rx_phase_q == uart_pkg::OVS_LAST);
   assign rx_done = rx_sample && (rx_state_q == uart_pkg::ST_STOP)
      && (!rx_stop2_q || !rx_bit);
   assign rx_frame_bad = !rx_bit;
   assign rx_keep = THIRD_CHANNEL || !mode_q[uart_pkg::MODE_SLEEP] || rx_shift_q[DW-1];
   assign rd_rxd = rd_en && (paddr == uart_pkg::OFS_RXD);
   assign clr_stat = wr_en && (paddr == uart_pkg::OFS_STAT);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_state_q <= uart_pkg::ST_IDLE;
         rx_shift_q <= '0;
         rx_phase_q <= '0;
         rx_idx_q <= '0;
         rx_par_bad_q <= 1'b0;
         rx_stop2_q <= 1'b0;
      end else if (!ctl_q[uart_pkg::CTL_RX_EN]) begin
         rx_state_q <= uart_pkg::ST_IDLE;
      end else if (tick16) begin
         rx_phase_q <= rx_phase_q + 1'b1;
         case (rx_state_q)
            uart_pkg::ST_IDLE: begin
               rx_phase_q <= '0;
               if (!rx_bit) begin
                  rx_state_q <= uart_pkg::ST_START;
               end
            end
            uart_pkg::ST_START: begin
               if (rx_phase_q == uart_pkg::OVS_MID) begin
                  rx_phase_q <= '0;
                  rx_idx_q <= '0;
                  rx_par_bad_q <= mode_q[uart_pkg::MODE_PAR_ODD];
                  rx_stop2_q <= mode_q[uart_pkg::MODE_TWO_STOP];
                  rx_state_q <= rx_bit ? uart_pkg::ST_IDLE : uart_pkg::ST_DATA;
               end
            end
            uart_pkg::ST_DATA: begin
               if (rx_sample) begin
                  rx_shift_q <= {rx_bit, rx_shift_q[DW-1:1]};
                  rx_par_bad_q <= rx_par_bad_q ^ rx_bit;
                  rx_idx_q <= rx_idx_q + 1'b1;
                  if (rx_idx_q == uart_pkg::LAST_DATA_BIT) begin
                     rx_state_q <= mode_q[uart_pkg::MODE_PAR_EN] ? uart_pkg::ST_PARITY
                        : uart_pkg::ST_STOP;
                  end
               end
            end
            uart_pkg::ST_PARITY: begin
               if (rx_sample) begin
                  rx_par_bad_q <= rx_par_bad_q ^ rx_bit;
                  rx_state_q <= uart_pkg::ST_STOP;
               end
            end
            default: begin
               if (rx_done) begin
                  rx_state_q <= uart_pkg::ST_IDLE;
               end else if (rx_sample) begin
                  rx_stop2_q <= 1'b0;
               end
            end
         endcase
      end
   end

   // hardware set wins over a software clear in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_buf_q <= '0;
         rx_full_q <= 1'b0;
         overrun_q <= 1'b0;
         framing_q <= 1'b0;
         parity_err_q <= 1'b0;
         collision_q <= 1'b0;
         rx_req <= 1'b0;
         collision_req <= 1'b0;
      end else begin
         rx_req <= 1'b0;
         collision_req <= col_hit;
         if (col_hit) begin
            collision_q <= 1'b1;
         end else if (clr_stat && pwdata[uart_pkg::STAT_COLLISION]) begin
            collision_q <= 1'b0;
         end
         if (rd_rxd) begin
            rx_full_q <= 1'b0;
         end
         if (clr_stat && pwdata[uart_pkg::STAT_OVERRUN]) begin
            overrun_q <= 1'b0;
         end
         if (clr_stat && pwdata[uart_pkg::STAT_FRAMING]) begin
            framing_q <= 1'b0;
         end
         if (clr_stat && pwdata[uart_pkg::STAT_PARITY]) begin
            parity_err_q <= 1'b0;
         end
         // sets below override the clears; a set arriving with a clear is never lost
         if (rx_done && rx_keep) begin
            rx_buf_q <= rx_shift_q;
            rx_full_q <= 1'b1;
            rx_req <= !rx_full_q;
            if (rx_full_q) begin
               overrun_q <= 1'b1;
            end
            if (rx_frame_bad) begin
               framing_q <= 1'b1;
            end
            if (mode_q[uart_pkg::MODE_PAR_EN] && rx_par_bad_q) begin
               parity_err_q <= 1'b1;
            end
         end
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
endmodule

// ===== verif/uart_channel_monitor.sv
// pin and request checks for the serial channel, bound to its ports
`timescale 1ns/1ps
module uart_channel_monitor (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic serial_out_pin_level,
   input wire logic serial_out_pin_oe,
   input wire logic serial_in_pin_sense,
   input wire logic rx_req,
   input wire logic tx_req,
   input wire logic collision_req
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   AST_RESET_IDLE: assert property ($rose(presetn) |->
      (serial_out_pin_level && serial_out_pin_oe) [*4]) else $error("line not idle");
   AST_OD_FLOAT: assert property (!serial_out_pin_oe |-> serial_out_pin_level)
      else $error("released line low");
   AST_BIT_HOLD: assert property ($changed(serial_out_pin_level) |=>
      $stable(serial_out_pin_level) [*8]) else $error("bit too short");
   AST_COLL_CAUSE: assert property (collision_req |->
      $past(serial_out_pin_level) != $past(serial_in_pin_sense)) else $error("false clash");
   AST_COLL_PULSE: assert property (collision_req |=> !collision_req)
      else $error("clash held");
   AST_TX_GAP: assert property (tx_req |=> !tx_req [*8]) else $error("tx pulse");
   AST_RX_PULSE: assert property (rx_req |=> !rx_req [*8]) else $error("rx pulse");
   AST_COLL_BUSY: assert property (tx_req |-> !collision_req) else $error("idle clash");
   cover property (collision_req);
   cover property (rx_req);
   cover property (tx_req);
endmodule
bind uart_channel uart_channel_monitor MON (.pclk(pclk), .presetn(presetn),
   .serial_out_pin_level(serial_out_pin_level), .serial_out_pin_oe(serial_out_pin_oe),
   .serial_in_pin_sense(serial_in_pin_sense), .rx_req(rx_req), .tx_req(tx_req),
   .collision_req(collision_req));

// ===== verif/uart_peer.sv
// far-end model: echoes the shared line, optionally fighting it
`timescale 1ns/1ps
module uart_peer (
   input wire logic lvl,
   input wire logic oe,
   input wire logic clash,
   output logic sense
);
   // pulled up while released, so a floating line reads high
   assign sense = (oe ? lvl : 1'b1) ^ clash;
endmodule

// ===== verif/uart_mode_pins_and_special_functions_tb_top.sv
// bench: loopback frames, line decode, collision and fifo fill for the channel
`timescale 1ns/1ps
module uart_mode_pins_and_special_functions_tb_top;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic clash = 1'b0, xs = 1'b0, fs = 1'b1, er, pready, pslverr, lvl, oe, sense;
   logic rx_req, tx_req, coll, xd, xo, fd, fo, lvl2, oe2, sense2, rx2;
   logic [7:0] paddr = 8'h00, d;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
   int bad_count = 0, cmp_count = 0, seed = 64, bt, n, m;
   int rx_n = 0, rx2_n = 0, coll_n = 0, tx_n = 0;
   uart_channel #(.THIRD_CHANNEL(1'b1)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .serial_out_pin_level(lvl), .serial_out_pin_oe(oe),
      .serial_in_pin_sense(sense), .xfer_clock_pin_sense(xs), .xfer_clock_pin_drive(xd),
      .xfer_clock_pin_oe(xo), .flow_control_pin_sense(fs), .flow_control_pin_drive(fd),
      .flow_control_pin_oe(fo), .rx_req(rx_req), .tx_req(tx_req), .collision_req(coll));
   uart_peer PEER (.lvl(lvl), .oe(oe), .clash(clash), .sense(sense));
   // first-channel copy on the same bus, only its receive requests are watched
   uart_channel #(.THIRD_CHANNEL(1'b0)) DUT2 (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(),
      .pready(), .pslverr(), .serial_out_pin_level(lvl2), .serial_out_pin_oe(oe2),
      .serial_in_pin_sense(sense2), .xfer_clock_pin_sense(xs), .xfer_clock_pin_drive(),
      .xfer_clock_pin_oe(), .flow_control_pin_sense(fs), .flow_control_pin_drive(),
      .flow_control_pin_oe(), .rx_req(rx2), .tx_req(), .collision_req());
   uart_peer PEER2 (.lvl(lvl2), .oe(oe2), .clash(1'b0), .sense(sense2));
   initial forever #4 pclk = ~pclk;
   always @(posedge pclk) begin
      if (rx_req === 1'b1) rx_n <= rx_n + 1;
      if (rx2 === 1'b1) rx2_n <= rx2_n + 1;
      if (coll === 1'b1) coll_n <= coll_n + 1;
      if (tx_req === 1'b1) tx_n <= tx_n + 1;
   end
   function automatic logic [31:0] frame_of(input logic [7:0] v);
      return 32'({1'b1, v, 1'b0});
   endfunction
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         bad_count++;
         $display("BAD %0t seen %h want %h", $time, s, e);
      end
   endtask
   task automatic wrap_up;
      if (bad_count == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic guard(input int k, input int lim);
      if (k >= lim) begin
         bad_count++;
         wrap_up();
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] wd);
      int k = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= 32'(wd);
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 3000);
      guard(k, 3000);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // decodes one frame at mid-bit; a wrong divider drifts off the bit centres
   task automatic line(input logic [7:0] want, input logic pol);
      logic [9:0] f;
      int k = 0;
      while ((lvl ^ pol) !== 1'b0 && k < 9000) begin
         @(posedge pclk);
         k++;
      end
      guard(k, 9000);
      repeat (bt / 2) @(posedge pclk);
      for (int j = 0; j < 10; j++) begin
         f[j] = lvl ^ pol;
         repeat (bt) @(posedge pclk);
      end
      chk(32'(f), frame_of(want));
   endtask
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      chk(32'(lvl), 32'h0000_0001);
      bus(1'b0, 8'h40, 8'h00);
      chk(32'(er), 32'h0000_0001);
      bt = 32 + 16 * ($random(seed) & 3);
      bus(1'b1, 8'h0C, 8'(bt / 16 - 1));
      bus(1'b1, 8'h00, 8'h00);
      // modes: open drain, data invert, polarity reverse, clash, input pin as output
      for (int k = 0; k < 5; k++) begin
         d = 8'($random(seed));
         clash <= (k == 3);
         bus(1'b1, 8'h08, 8'h00);
         bus(1'b1, 8'h04, (k == 2) ? 8'h50 : (k == 0) ? 8'h30 : 8'h10);
         bus(1'b1, 8'h1C, 8'(k == 4));
         chk(32'(oe), 32'(k != 0));
         bus(1'b1, 8'h08, (k == 1) ? 8'h45 : 8'h05);
         n = rx_n;
         m = coll_n;
         bus(1'b1, 8'h10, d);
         line((k == 1) ? ~d : d, k == 2);
         repeat (bt) @(posedge pclk);
         chk(32'(coll_n != m), 32'(k == 3));
         if (k != 3) chk(32'(rx_n != n), 32'(k != 4));
         bus(1'b0, 8'h14, 8'h00);
         if (k < 3) chk(rd, 32'(d));
      end
      // sleep on the first-channel copy drops a character whose top bit is clear
      bus(1'b1, 8'h08, 8'h00);
      bus(1'b1, 8'h04, 8'h04);
      bus(1'b1, 8'h1C, 8'h02);
      bus(1'b1, 8'h00, 8'h80);
      bus(1'b1, 8'h08, 8'h05);
      n = rx2_n;
      m = tx_n;
      d = 8'($random(seed)) & 8'h7F;
      for (int j = 0; j < 2; j++) begin
         bus(1'b1, 8'h10, d);
         if (j == 0) chk(32'({fo, fd, xo, xd}), 32'h0000_000B);
         line(d, 1'b0);
         repeat (bt) @(posedge pclk);
         chk(32'(rx2_n - n), 32'(j));
         bus(1'b0, 8'h14, 8'h00);
         d[7] = 1'b1;
      end
      chk(32'(tx_n - m), 32'h0000_0002);
      // clear-to-send held high stalls the sender while the fifo fills
      bus(1'b1, 8'h04, 8'h00);
      bus(1'b1, 8'h1C, 8'h00);
      bus(1'b1, 8'h08, 8'h01);
      repeat (uart_pkg::FIFO_DEPTH) bus(1'b1, 8'h10, 8'($random(seed)));
      bus(1'b0, 8'h18, 8'h00);
      chk(32'(rd[1:0]), 32'h0000_0001);
      fs <= 1'b0;
      bus(1'b1, 8'h10, 8'h5A);
      n = 0;
      do begin
         bus(1'b0, 8'h18, 8'h00);
         n++;
      end while (rd[uart_pkg::STAT_TX_EMPTY] !== 1'b1 && n < 9000);
      guard(n, 9000);
      chk(32'(rd[1:0]), 32'h0000_0002);
      wrap_up();
   end
endmodule
